// >>> design/sfsc_pkg.sv
// Constants, types and field layout of the flash status and configuration registers
// Function
// RULE1: Protect mode 00 accepts status writes only with write latch set; pin ignored.
// RULE2: Protect mode 01 with write-protect pin low refuses every status write.
// RULE3: Protect mode 01 with pin high accepts status writes once write latch set.
// RULE4: Protect mode 10 refuses status writes until power cycle, which restores 00.
// RULE5: Protect mode 11 refuses every status write permanently.
// RULE6: Quad enable 1 turns protect and pause pins into quad lines; pin protection lost.
// RULE7: Host keeps quad enable 0 when protect or pause pin is tied to a rail.
// RULE8: Fail flag sets when program or erase fails, is reset, or hits protection; code sets it only from pe_fail at pe_done.
// RULE9: Fail flag clears when next program or erase succeeds; never stops operations.
// RULE10: Three security lock bits default 0, set individually, never clear again.
// RULE11: Non-volatile complement bit at position 14 joins block-protect area select.
// RULE12: Suspend flag at position 15 sets on either suspend command code.
// RULE13: Suspend flag clears on resume, two-command software reset, or power cycle.
// RULE14: Volatile page-size bit at config position 4: 0 gives 256, 1 gives 1024 bytes.
// RULE15: Small page wraps buffer load at 256; large page uses whole 1024 buffer.
// RULE16: With large page, page erase erases the whole 1024-byte page.
// RULE17: Drive bits 6:5 give 00=80%, 01=40%, 10=100%, 11=60% (default).
// RULE18: Dummy bit: dual read 4 or 8 cycles, quad read 6 or 10 cycles.
// RULE19: Protect, quad, complement, drive, dummy bits persist; page size resets.
// RULE20: Quad-line commands and quad command mode are refused unless quad enable set.
// RULE21: With write latch clear, status write, program and erase are not accepted.
// RULE22: A status write refused by protection leaves every register bit unchanged.
package sfsc_pkg;

	localparam int STATUS_W = 16;
	localparam int CONFIG_W = 8;

	// Status field positions
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_SRP_LO = 7;
	localparam int ST_SRP_HI = 8;
	localparam int ST_QE = 9;
	localparam int ST_FAIL = 10;
	localparam int ST_CMP = 14;
	localparam int ST_SUS = 15;
	localparam int ST_LB_LO = 11;
	localparam int ST_LB_HI = 13;

	// Config field positions
	localparam int CF_DUMMY = 0;
	localparam int CF_PAGE = 4;
	localparam int CF_DRV_LO = 5;
	localparam int CF_DRV_HI = 6;

	// Write and retention masks
	localparam logic [15:0] SR_WRITE_MASK = 16'h43FC;
	localparam logic [15:0] SR_LOCK_MASK = 16'h3800;
	localparam logic [15:0] SR_VOLATILE_MASK = 16'h8403;
	localparam logic [15:0] SR_SRP_MASK = 16'h0180;
	localparam logic [7:0] CR_WRITE_MASK = 8'h71;
	localparam logic [7:0] CR_NV_MASK = 8'h61;
	localparam logic [7:0] CR_RESET = 8'h60;

	typedef enum logic [1:0] {
		SRP_SOFT = 2'b00,
		SRP_HW = 2'b01,
		SRP_LOCK = 2'b10,
		SRP_OTP = 2'b11
	} sfsc_srp_t;

	typedef enum logic [1:0] {
		PH_CMD = 2'b00,
		PH_DATA = 2'b01
	} sfsc_phase_t;

	// Command codes
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_RDSR_LO = 8'h05;
	localparam logic [7:0] CMD_RDSR_HI = 8'h35;
	localparam logic [7:0] CMD_RDCR = 8'h15;
	localparam logic [7:0] CMD_WRSR = 8'h01;
	localparam logic [7:0] CMD_WRSR_HI = 8'h31;
	localparam logic [7:0] CMD_SUSP_A = 8'h75;
	localparam logic [7:0] CMD_SUSP_B = 8'hB0;
	localparam logic [7:0] CMD_RESM_A = 8'h7A;
	localparam logic [7:0] CMD_RESM_B = 8'h30;
	localparam logic [7:0] CMD_RST_EN = 8'h66;
	localparam logic [7:0] CMD_RST = 8'h99;
	localparam logic [7:0] CMD_PP = 8'h02;
	localparam logic [7:0] CMD_PW = 8'hA5;
	localparam logic [7:0] CMD_DPP = 8'hA2;
	localparam logic [7:0] CMD_QPP = 8'h32;
	localparam logic [7:0] CMD_PE = 8'h81;
	localparam logic [7:0] CMD_SE = 8'h20;
	localparam logic [7:0] CMD_HBE = 8'h52;
	localparam logic [7:0] CMD_BE = 8'hD8;
	localparam logic [7:0] CMD_CE_A = 8'h60;
	localparam logic [7:0] CMD_CE_B = 8'hC7;
	localparam logic [7:0] CMD_QREAD = 8'h6B;
	localparam logic [7:0] CMD_QIO_READ = 8'hEB;
	localparam logic [7:0] CMD_QIO_WORD = 8'hE7;
	localparam logic [7:0] CMD_QIO_OCT = 8'hE3;
	localparam logic [7:0] CMD_QPI_EN = 8'h38;

	// Decoded configuration values
	localparam logic [3:0] DUAL_DUMMY_SHORT = 4'h4;
	localparam logic [3:0] DUAL_DUMMY_LONG = 4'h8;
	localparam logic [3:0] QUAD_DUMMY_SHORT = 4'h6;
	localparam logic [3:0] QUAD_DUMMY_LONG = 4'hA;
	localparam logic [6:0] DRIVE_PCT_00 = 7'h50;
	localparam logic [6:0] DRIVE_PCT_01 = 7'h28;
	localparam logic [6:0] DRIVE_PCT_10 = 7'h64;
	localparam logic [6:0] DRIVE_PCT_11 = 7'h3C;
	localparam logic [9:0] PAGE_MASK_SMALL = 10'h0FF;
	localparam logic [9:0] PAGE_MASK_LARGE = 10'h3FF;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic si;
		logic wp_n;
	} sfsc_pins_t;

	localparam logic [3:0] PINS_IDLE = 4'h5;

	typedef struct packed {
		logic [9:0] page_mask;
		logic [6:0] drive_pct;
		logic [3:0] dual_dummy;
		logic [3:0] quad_dummy;
	} sfsc_cfg_t;

	typedef struct packed {
		logic sclk_prev;
		logic cs_prev;
		sfsc_phase_t phase;
		logic [2:0] bitcnt;
		logic [7:0] shin;
		logic [7:0] cmd;
		logic [1:0] nbytes;
		logic [15:0] wr_sr;
		logic [7:0] wr_cr;
		logic [7:0] out_sr;
		logic so;
		logic so_oe_n;
		logic rst_armed;
		logic [15:0] status_word;
		logic [7:0] config_word;
		sfsc_cfg_t cfg;
		logic quad_pins;
		logic nv_save;
		logic cmd_accept;
		logic cmd_reject;
		logic [7:0] cmd_code;
	} sfsc_state_t;

endpackage

// >>> design/sfsc_sync.sv
// Two-flop synchroniser for the serial link pins
`timescale 1ns/1ps
module sfsc_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta_q <= RST_VAL;
			dout <= RST_VAL;
		end else if (ce) begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

// >>> design/sfsc_decode.sv
// Decode of configuration word into page, drive and latency settings
`timescale 1ns/1ps
module sfsc_decode (
	input wire logic [7:0] config_word,
	output sfsc_pkg::sfsc_cfg_t cfg
);
	always_comb begin
		cfg.page_mask = config_word[sfsc_pkg::CF_PAGE] ? sfsc_pkg::PAGE_MASK_LARGE :
			sfsc_pkg::PAGE_MASK_SMALL; // RULE14 RULE15 RULE16
		case (config_word[sfsc_pkg::CF_DRV_HI:sfsc_pkg::CF_DRV_LO]) // RULE17
			2'b00: cfg.drive_pct = sfsc_pkg::DRIVE_PCT_00;
			2'b01: cfg.drive_pct = sfsc_pkg::DRIVE_PCT_01;
			2'b10: cfg.drive_pct = sfsc_pkg::DRIVE_PCT_10;
			default: cfg.drive_pct = sfsc_pkg::DRIVE_PCT_11;
		endcase
		if (config_word[sfsc_pkg::CF_DUMMY]) begin // RULE18
			cfg.dual_dummy = sfsc_pkg::DUAL_DUMMY_LONG;
			cfg.quad_dummy = sfsc_pkg::QUAD_DUMMY_LONG;
		end else begin
			cfg.dual_dummy = sfsc_pkg::DUAL_DUMMY_SHORT;
			cfg.quad_dummy = sfsc_pkg::QUAD_DUMMY_SHORT;
		end
	end
endmodule

// >>> design/sfsc_regs.sv
// Status and configuration registers behind the serial command link
`timescale 1ns/1ps
module sfsc_regs (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic si_pin,
	input wire logic wp_n_pin,
	input wire logic array_busy,
	input wire logic pe_done,
	input wire logic pe_fail,
	input wire logic [15:0] nv_status,
	input wire logic [7:0] nv_config,
	output logic so_q,
	output logic so_oe_n_q,
	output logic [15:0] status_word_q,
	output logic [7:0] config_word_q,
	output logic quad_pins_q,
	output logic nv_save_q,
	output logic cmd_accept_q,
	output logic cmd_reject_q,
	output logic [7:0] cmd_code_q,
	output logic [9:0] page_mask_q,
	output logic [6:0] drive_pct_q,
	output logic [3:0] dual_dummy_q,
	output logic [3:0] quad_dummy_q
);
	sfsc_pkg::sfsc_state_t st_q;
	sfsc_pkg::sfsc_state_t st_d;
	sfsc_pkg::sfsc_state_t st_rst;
	sfsc_pkg::sfsc_pins_t pins_s;
	sfsc_pkg::sfsc_cfg_t cfg_dec;
	sfsc_pkg::sfsc_srp_t srp;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic cs_low;
	logic byte_done;
	logic cmd_done;
	logic [7:0] byte_in;
	logic qe;
	logic write_latch_flag;
	logic wp_eff;
	logic wr_allowed;
	logic wr_req;
	logic wr_ok;
	logic is_wr_cmd;

	function automatic logic is_pe_cmd(input logic [7:0] c);
		is_pe_cmd = (c == sfsc_pkg::CMD_PP) || (c == sfsc_pkg::CMD_PW) ||
			(c == sfsc_pkg::CMD_DPP) || (c == sfsc_pkg::CMD_QPP) ||
			(c == sfsc_pkg::CMD_PE) || (c == sfsc_pkg::CMD_SE) ||
			(c == sfsc_pkg::CMD_HBE) || (c == sfsc_pkg::CMD_BE) ||
			(c == sfsc_pkg::CMD_CE_A) || (c == sfsc_pkg::CMD_CE_B);
	endfunction

	function automatic logic is_quad_cmd(input logic [7:0] c);
		is_quad_cmd = (c == sfsc_pkg::CMD_QPP) || (c == sfsc_pkg::CMD_QREAD) ||
			(c == sfsc_pkg::CMD_QIO_READ) || (c == sfsc_pkg::CMD_QIO_WORD) ||
			(c == sfsc_pkg::CMD_QIO_OCT) || (c == sfsc_pkg::CMD_QPI_EN);
	endfunction

	function automatic logic [7:0] read_byte(input logic [7:0] c, input logic [15:0] sr,
		input logic [7:0] cr);
		if (c == sfsc_pkg::CMD_RDSR_HI) begin
			read_byte = sr[15:8];
		end else if (c == sfsc_pkg::CMD_RDCR) begin
			read_byte = cr;
		end else begin
			read_byte = sr[7:0];
		end
	endfunction

	sfsc_sync #(
		.W(4),
		.RST_VAL(sfsc_pkg::PINS_IDLE)
	) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.ce(ce),
		.din({sclk_pin, cs_n_pin, si_pin, wp_n_pin}),
		.dout(pins_s)
	);

	sfsc_decode u_decode (
		.config_word(st_q.config_word),
		.cfg(cfg_dec)
	);

	// Edges of the synchronised link
	assign sclk_rise = ce & pins_s.sclk & ~st_q.sclk_prev;
	assign sclk_fall = ce & ~pins_s.sclk & st_q.sclk_prev;
	assign cs_rise = ce & pins_s.cs_n & ~st_q.cs_prev;
	assign cs_low = ~pins_s.cs_n;
	assign byte_in = {st_q.shin[6:0], pins_s.si};
	assign byte_done = sclk_rise & cs_low & (st_q.bitcnt == 3'h7);
	assign cmd_done = byte_done & (st_q.phase == sfsc_pkg::PH_CMD);

	// Write protection decision
	assign qe = st_q.status_word[sfsc_pkg::ST_QE];
	assign write_latch_flag = st_q.status_word[sfsc_pkg::ST_WEL];
	assign srp = sfsc_pkg::sfsc_srp_t'(st_q.status_word[sfsc_pkg::ST_SRP_HI:sfsc_pkg::ST_SRP_LO]);
	assign wp_eff = pins_s.wp_n | qe; // RULE6
	assign wr_allowed = write_latch_flag & ((srp == sfsc_pkg::SRP_SOFT) | // RULE1 RULE21
		((srp == sfsc_pkg::SRP_HW) & wp_eff)); // RULE2 RULE3 RULE4 RULE5
	assign is_wr_cmd = (st_q.cmd == sfsc_pkg::CMD_WRSR) | (st_q.cmd == sfsc_pkg::CMD_WRSR_HI);
	assign wr_req = cs_rise & (st_q.phase == sfsc_pkg::PH_DATA) & is_wr_cmd &
		(st_q.nbytes != 2'h0);
	assign wr_ok = wr_req & wr_allowed;

	// Power-up image: retained bits from storage, volatile bits at default
	always_comb begin
		st_rst = '0;
		st_rst.cs_prev = 1'b1;
		st_rst.so_oe_n = 1'b1;
		st_rst.phase = sfsc_pkg::PH_CMD;
		st_rst.status_word = nv_status & ~sfsc_pkg::SR_VOLATILE_MASK; // RULE19 RULE13
		if (nv_status[sfsc_pkg::ST_SRP_HI:sfsc_pkg::ST_SRP_LO] == sfsc_pkg::SRP_LOCK) begin
			st_rst.status_word = st_rst.status_word & ~sfsc_pkg::SR_SRP_MASK; // RULE4
		end
		st_rst.config_word = nv_config & sfsc_pkg::CR_NV_MASK; // RULE19 RULE14
		st_rst.wr_sr = st_rst.status_word;
		st_rst.wr_cr = st_rst.config_word;
		st_rst.cfg.page_mask = sfsc_pkg::PAGE_MASK_SMALL;
		st_rst.cfg.drive_pct = sfsc_pkg::DRIVE_PCT_11;
		st_rst.cfg.dual_dummy = sfsc_pkg::DUAL_DUMMY_SHORT;
		st_rst.cfg.quad_dummy = sfsc_pkg::QUAD_DUMMY_SHORT;
	end

	always_comb begin
		st_d = st_q;
		if (ce) begin
			st_d.sclk_prev = pins_s.sclk;
			st_d.cs_prev = pins_s.cs_n;
			st_d.cmd_accept = 1'b0;
			st_d.cmd_reject = 1'b0;
			st_d.nv_save = 1'b0;
			st_d.status_word[sfsc_pkg::ST_BUSY] = array_busy;
			if (pe_done) begin
				st_d.status_word[sfsc_pkg::ST_FAIL] = pe_fail; // RULE8 RULE9
			end
			if (!cs_low) begin
				st_d.phase = sfsc_pkg::PH_CMD;
				st_d.bitcnt = 3'h0;
				st_d.so_oe_n = 1'b1;
				st_d.nbytes = 2'h0;
			end else if (sclk_rise) begin
				st_d.shin = byte_in;
				st_d.bitcnt = st_q.bitcnt + 3'h1;
			end
			if (sclk_fall && cs_low && !st_q.so_oe_n) begin
				st_d.so = st_q.out_sr[7];
				st_d.out_sr = {st_q.out_sr[6:0], 1'b0};
			end
			if (cmd_done) begin
				st_d.cmd = byte_in;
				st_d.cmd_code = byte_in;
				st_d.phase = sfsc_pkg::PH_DATA;
				st_d.wr_sr = st_q.status_word;
				st_d.wr_cr = st_q.config_word;
				st_d.rst_armed = (byte_in == sfsc_pkg::CMD_RST_EN);
				st_d.cmd_accept = 1'b1;
				case (byte_in)
					sfsc_pkg::CMD_WREN: begin
						st_d.status_word[sfsc_pkg::ST_WEL] = 1'b1;
					end
					sfsc_pkg::CMD_WRDI: begin
						st_d.status_word[sfsc_pkg::ST_WEL] = 1'b0;
					end
					sfsc_pkg::CMD_RDSR_LO, sfsc_pkg::CMD_RDSR_HI, sfsc_pkg::CMD_RDCR: begin
						st_d.out_sr = read_byte(byte_in, st_q.status_word, st_q.config_word);
						st_d.so_oe_n = 1'b0;
					end
					sfsc_pkg::CMD_SUSP_A, sfsc_pkg::CMD_SUSP_B: begin
						st_d.status_word[sfsc_pkg::ST_SUS] = 1'b1; // RULE12
					end
					sfsc_pkg::CMD_RESM_A, sfsc_pkg::CMD_RESM_B: begin
						st_d.status_word[sfsc_pkg::ST_SUS] = 1'b0; // RULE13
					end
					sfsc_pkg::CMD_RST: begin
						if (st_q.rst_armed) begin
							st_d.status_word[sfsc_pkg::ST_SUS] = 1'b0; // RULE13
							st_d.status_word[sfsc_pkg::ST_WEL] = 1'b0;
							st_d.config_word[sfsc_pkg::CF_PAGE] = 1'b0;
						end
					end
					default: begin
						if (is_pe_cmd(byte_in)) begin
							if (!write_latch_flag || (is_quad_cmd(byte_in) && !qe)) begin
								st_d.cmd_accept = 1'b0; // RULE21 RULE20
								st_d.cmd_reject = 1'b1;
							end else begin
								st_d.status_word[sfsc_pkg::ST_WEL] = 1'b0;
							end
						end else if (is_quad_cmd(byte_in) && !qe) begin
							st_d.cmd_accept = 1'b0; // RULE20
							st_d.cmd_reject = 1'b1;
						end
					end
				endcase
			end else if (byte_done && st_q.phase == sfsc_pkg::PH_DATA) begin
				if (!st_q.so_oe_n) begin
					st_d.out_sr = read_byte(st_q.cmd, st_q.status_word, st_q.config_word);
				end else if (st_q.nbytes != 2'h3) begin
					st_d.nbytes = st_q.nbytes + 2'h1;
					if (st_q.cmd == sfsc_pkg::CMD_WRSR_HI) begin
						if (st_q.nbytes == 2'h0) begin
							st_d.wr_sr[15:8] = byte_in;
						end else if (st_q.nbytes == 2'h1) begin
							st_d.wr_cr = byte_in;
						end
					end else begin
						case (st_q.nbytes)
							2'h0: st_d.wr_sr[7:0] = byte_in;
							2'h1: st_d.wr_sr[15:8] = byte_in;
							2'h2: st_d.wr_cr = byte_in;
							default: st_d.wr_cr = st_q.wr_cr;
						endcase
					end
				end
			end
			// Commit at deselect; refused writes change nothing
			if (wr_ok) begin // RULE22
				st_d.status_word = (st_q.status_word & ~sfsc_pkg::SR_WRITE_MASK) |
					(st_q.wr_sr & sfsc_pkg::SR_WRITE_MASK) | // RULE11
					(st_q.wr_sr & sfsc_pkg::SR_LOCK_MASK); // RULE10
				st_d.status_word[sfsc_pkg::ST_WEL] = 1'b0;
				st_d.status_word[sfsc_pkg::ST_BUSY] = array_busy;
				st_d.status_word[sfsc_pkg::ST_SUS] = st_q.status_word[sfsc_pkg::ST_SUS];
				st_d.status_word[sfsc_pkg::ST_FAIL] = pe_done ? pe_fail :
					st_q.status_word[sfsc_pkg::ST_FAIL];
				st_d.config_word = (st_q.config_word & ~sfsc_pkg::CR_WRITE_MASK) |
					(st_q.wr_cr & sfsc_pkg::CR_WRITE_MASK); // RULE14 RULE17 RULE18
				st_d.nv_save = 1'b1; // RULE19
			end
			st_d.cfg = cfg_dec;
			st_d.quad_pins = st_d.status_word[sfsc_pkg::ST_QE]; // RULE6
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_q <= st_rst;
		end else begin
			st_q <= st_d;
		end
	end

	assign so_q = st_q.so;
	assign so_oe_n_q = st_q.so_oe_n;
	assign status_word_q = st_q.status_word;
	assign config_word_q = st_q.config_word;
	assign quad_pins_q = st_q.quad_pins;
	assign nv_save_q = st_q.nv_save;
	assign cmd_accept_q = st_q.cmd_accept;
	assign cmd_reject_q = st_q.cmd_reject;
	assign cmd_code_q = st_q.cmd_code;
	assign page_mask_q = st_q.cfg.page_mask;
	assign drive_pct_q = st_q.cfg.drive_pct;
	assign dual_dummy_q = st_q.cfg.dual_dummy;
	assign quad_dummy_q = st_q.cfg.quad_dummy;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sequence s_refused_write;
		wr_req && !wr_allowed && !pe_done;
	endsequence

	a_write_needs_latch: assert property ((wr_req && !write_latch_flag) |=> !nv_save_q) // RULE1
		else $error("status write taken with write latch clear");
	a_hw_lock_refuses: assert property ((wr_req && srp == sfsc_pkg::SRP_HW && !pins_s.wp_n
		&& !qe) |=> !nv_save_q) // RULE2
		else $error("status write taken with protect pin low");
	a_hw_open_accepts: assert property ((wr_req && srp == sfsc_pkg::SRP_HW && pins_s.wp_n
		&& write_latch_flag) |=> nv_save_q) // RULE3
		else $error("status write lost with protect pin high");
	a_lockdown_refuses: assert property ((srp == sfsc_pkg::SRP_LOCK && wr_req) |=>
		!nv_save_q) // RULE4
		else $error("status write taken in lock-down mode");
	a_otp_refuses: assert property ((srp == sfsc_pkg::SRP_OTP && wr_req) |=>
		!nv_save_q) // RULE5
		else $error("status write taken in permanent mode");
	a_lock_bits_sticky: assert property (ce |=> ((status_word_q[13:11] &
		$past(status_word_q[13:11])) == $past(status_word_q[13:11]))) // RULE10
		else $error("security lock bit cleared");
	a_fail_flag_follow: assert property ((ce && pe_done) |=>
		status_word_q[sfsc_pkg::ST_FAIL] == $past(pe_fail)) // RULE8
		else $error("fail flag does not follow result");
	a_suspend_sets: assert property ((cmd_done && (byte_in == sfsc_pkg::CMD_SUSP_A ||
		byte_in == sfsc_pkg::CMD_SUSP_B)) |=> status_word_q[sfsc_pkg::ST_SUS]) // RULE12
		else $error("suspend flag not set");
	a_refused_holds: assert property (s_refused_write |=> ($stable(config_word_q) &&
		$stable(status_word_q[15:2]))) // RULE22
		else $error("refused write changed a register");
	a_pe_needs_latch: assert property ((cmd_done && is_pe_cmd(byte_in) && !write_latch_flag) |=>
		(cmd_reject_q && !cmd_accept_q)) // RULE21
		else $error("program or erase taken with latch clear");
	a_page_mask: assert property (ce |=> (page_mask_q == ($past(config_word_q[4]) ?
		sfsc_pkg::PAGE_MASK_LARGE : sfsc_pkg::PAGE_MASK_SMALL))) // RULE15
		else $error("page wrap mask wrong");
endmodule

// >>> sim/sfsc_host.sv
// Behavioural host controller driving the serial command link
`timescale 1ns/1ps
module sfsc_host (
	input wire logic so,
	input wire logic so_oe_n,
	output sfsc_pkg::sfsc_pins_t pins,
	output logic rd_stb,
	output logic [7:0] rd_byte
);
	initial begin
		pins = sfsc_pkg::PINS_IDLE;
		rd_stb = 1'b0;
		rd_byte = 8'h00;
	end

	// Protect pin is driven by the host, never tied to a rail
	task automatic set_wp(input logic v);
		pins.wp_n = v;
	endtask

	// Frame: command, n bytes out, nin bytes read back; clock idles low
	task automatic frame(input logic [7:0] c, input int n, input logic [23:0] d, input int nin);
		logic [31:0] v;
		logic [7:0] rb;
		int nb;
		v = {c, d};
		rb = 8'h00;
		nb = 8 + 8 * n;
		#7 pins.cs_n = 1'b0;
		#24;
		for (int i = 0; i < nb + 8 * nin; i++) begin
			pins.si = (i < nb) ? v[31 - i] : ~pins.si;
			#24 pins.sclk = 1'b1;
			if (i >= nb) begin
				rb = {rb[6:0], so_oe_n ? ~so : so};
				if ((i - nb) % 8 == 7) begin
					rd_byte = rb;
					rd_stb = 1'b1;
				end
			end
			#24 pins.sclk = 1'b0;
			rd_stb = 1'b0;
		end
		#24 pins.cs_n = 1'b1;
		pins.si = ~pins.si;
	endtask
endmodule

// >>> sim/sfsc_regs_test.sv
// Self-checking bench for the status and configuration registers
`timescale 1ns/1ps
module sfsc_regs_test;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic array_busy = 1'b0;
	logic pe_done = 1'b0;
	logic pe_fail = 1'b0;
	logic [15:0] nv_status = 16'h0000;
	logic [7:0] nv_config = 8'h60;
	sfsc_pkg::sfsc_pins_t pins;
	logic so;
	logic so_oe_n;
	logic quad_pins;
	logic rd_stb;
	logic [7:0] rd_byte;
	logic [9:0] page_mask;
	logic [6:0] drive_pct;
	logic [3:0] dual_dummy;
	logic [3:0] quad_dummy;
	logic ce = 1'b1;
	logic [15:0] status_word;
	logic [7:0] config_word;
	logic nv_save;
	logic cmd_accept;
	logic cmd_reject;
	logic [7:0] cmd_code;
	logic [9:0] last_cmd = 10'h000;
	int saves = 0;
	logic [15:0] exp_q[$];
	logic [6:0] drv_tab [4] = '{7'h50, 7'h28, 7'h64, 7'h3C};
	logic [7:0] sus_tab [3] = '{8'h75, 8'hB0, 8'h75};
	logic [7:0] res_tab [3] = '{8'h7A, 8'h30, 8'h66};
	int miscompares = 0;
	int tests_run = 0;

	always #2.5 clock = ~clock;

	sfsc_regs sfsc_regs_i (
		.clock(clock),
		.sys_rst(sys_rst),
		.ce(ce),
		.sclk_pin(pins.sclk),
		.cs_n_pin(pins.cs_n),
		.si_pin(pins.si),
		.wp_n_pin(pins.wp_n),
		.array_busy(array_busy),
		.pe_done(pe_done),
		.pe_fail(pe_fail),
		.nv_status(nv_status),
		.nv_config(nv_config),
		.so_q(so),
		.so_oe_n_q(so_oe_n),
		.status_word_q(status_word),
		.config_word_q(config_word),
		.quad_pins_q(quad_pins),
		.nv_save_q(nv_save),
		.cmd_accept_q(cmd_accept),
		.cmd_reject_q(cmd_reject),
		.cmd_code_q(cmd_code),
		.page_mask_q(page_mask),
		.drive_pct_q(drive_pct),
		.dual_dummy_q(dual_dummy),
		.quad_dummy_q(quad_dummy)
	);

	sfsc_host sfsc_host_i (
		.so(so),
		.so_oe_n(so_oe_n),
		.pins(pins),
		.rd_stb(rd_stb),
		.rd_byte(rd_byte)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] e);
		tests_run++;
		if (got !== e) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask

	// Read bytes from the link are matched against the oldest note
	always @(posedge rd_stb) begin
		if (exp_q.size() > 0) begin
			chk({8'h00, rd_byte}, exp_q.pop_front());
		end else begin
			chk({8'h00, rd_byte}, 16'hXXXX);
		end
	end

	task automatic gap();
		repeat (12) @(negedge clock);
	endtask

	task automatic op(input logic [7:0] c, input int n = 0, input logic [23:0] d = 24'h000000);
		sfsc_host_i.frame(c, n, d, 0);
		gap();
	endtask

	task automatic wr(input logic [7:0] c, input int n, input logic [23:0] d);
		op(8'h06);
		op(c, n, d);
	endtask

	task automatic rd(input logic [7:0] c, input logic [7:0] e);
		exp_q.push_back({8'h00, e});
		sfsc_host_i.frame(c, 0, 24'h000000, 1);
		gap();
	endtask

	task automatic pwr(input logic [15:0] s, input logic [7:0] c);
		@(negedge clock);
		nv_status = s;
		nv_config = c;
		sys_rst = 1'b1;
		repeat (5) @(negedge clock);
		sys_rst = 1'b0;
		gap();
	endtask

	task automatic pe_pulse(input logic f);
		@(negedge clock);
		pe_fail = f;
		pe_done = 1'b1;
		@(negedge clock);
		pe_done = 1'b0;
		gap();
	endtask

	task automatic cfg_chk(input logic [7:0] c);
		chk({6'h00, page_mask}, c[4] ? 16'h03FF : 16'h00FF);
		chk({9'h000, drive_pct}, {9'h000, drv_tab[c[6:5]]});
		chk({12'h000, dual_dummy}, c[0] ? 16'h0008 : 16'h0004);
		chk({12'h000, quad_dummy}, c[0] ? 16'h000A : 16'h0006);
	endtask

	// Last command verdict and count of stored writes
	always @(negedge clock) begin
		if (cmd_accept || cmd_reject) begin
			last_cmd = {cmd_accept, cmd_reject, cmd_code};
		end
		if (nv_save) begin
			saves++;
		end
	end

	task automatic regs(input logic [15:0] s, input logic [7:0] c);
		chk(status_word, s);
		chk({8'h00, config_word}, {8'h00, c});
	endtask

	task automatic cmdc(input logic [9:0] e);
		chk({6'h00, last_cmd}, {6'h00, e});
	endtask

	task automatic sv(input int e);
		chk(16'(saves), 16'(e));
	endtask

	task automatic tend(input string s);
		$display("test %s finished", s);
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge clock);
		miscompares++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, 16'h0001, 16'h0000);
		test_done();
	end

	initial begin
		logic [7:0] c;
		void'($urandom(32'h52C6));
		pwr(16'hFFFF, 8'hFF);
		rd(8'h05, 8'hFC);
		rd(8'h35, 8'h7B);
		rd(8'h15, 8'h61);
		cfg_chk(8'h61);
		wr(8'h01, 3, 24'h000000);
		rd(8'h05, 8'hFE);
		rd(8'h35, 8'h7B);
		regs(16'h7BFE, 8'h61);
		sv(0);
		tend("permanent_lock");
		pwr(16'h0000, 8'h60);
		wr(8'h01, 2, 24'h000100);
		rd(8'h35, 8'h01);
		wr(8'h01, 2, 24'hFC0000);
		rd(8'h05, 8'h02);
		rd(8'h35, 8'h01);
		pwr(16'h0100, 8'h60);
		rd(8'h35, 8'h00);
		regs(16'h0000, 8'h60);
		op(8'h02);
		cmdc(10'h102);
		tend("lockdown");
		op(8'h01, 1, 24'h7C0000);
		rd(8'h05, 8'h00);
		sfsc_host_i.set_wp(1'b0);
		wr(8'h01, 1, 24'h7C0000);
		rd(8'h05, 8'h7C);
		wr(8'h01, 1, 24'h800000);
		wr(8'h01, 1, 24'h040000);
		rd(8'h05, 8'h82);
		sfsc_host_i.set_wp(1'b1);
		wr(8'h01, 1, 24'h040000);
		rd(8'h05, 8'h04);
		op(8'h06);
		op(8'h04);
		rd(8'h05, 8'h04);
		sv(4);
		tend("protect_modes");
		wr(8'h32, 0, 24'h000000);
		cmdc(10'h132);
		rd(8'h05, 8'h06);
		op(8'h6B);
		cmdc(10'h16B);
		wr(8'h01, 2, 24'h040200);
		chk({15'h0000, quad_pins}, 16'h0001);
		wr(8'h32, 0, 24'h000000);
		cmdc(10'h232);
		rd(8'h05, 8'h04);
		wr(8'h01, 2, 24'h040000);
		chk({15'h0000, quad_pins}, 16'h0000);
		tend("quad");
		wr(8'h31, 1, 24'h480000);
		rd(8'h35, 8'h48);
		wr(8'h31, 1, 24'h100000);
		rd(8'h35, 8'h18);
		regs(16'h1804, 8'h60);
		tend("lock_bits");
		for (int i = 0; i < 3; i++) begin
			op(sus_tab[i]);
			rd(8'h35, 8'h98);
			op(res_tab[i]);
			if (i == 2) op(8'h99);
			rd(8'h35, 8'h18);
		end
		tend("suspend");
		pe_pulse(1'b1);
		rd(8'h35, 8'h1C);
		pe_pulse(1'b0);
		rd(8'h35, 8'h18);
		@(negedge clock);
		array_busy = 1'b1;
		rd(8'h05, 8'h05);
		array_busy = 1'b0;
		tend("fail_flag");
		for (int i = 0; i < 4; i++) begin
			c = 8'($urandom);
			c[6:5] = 2'(i);
			c[4] = i[0];
			c[0] = i[1];
			wr(8'h31, 2, {8'h18, c, 8'h00});
			rd(8'h15, c & 8'h71);
			cfg_chk(c & 8'h71);
		end
		pwr(16'h0000, 8'h71);
		rd(8'h15, 8'h61);
		cfg_chk(8'h61);
		regs(16'h0000, 8'h61);
		sv(12);
		@(negedge clock);
		ce = 1'b0;
		op(8'h06);
		ce = 1'b1;
		rd(8'h05, 8'h00);
		tend("config");
		test_done();
	end
endmodule
